/* File: gpc_pkg.sv */
// Purpose: shared constants for the eight-pin general purpose port
// Assumes: registers reached only through the serial programming port
// Notes: offsets are byte offsets inside the configuration space
package gpc_pkg;
  localparam int NUM_PINS = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W = 6;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_DATA = 12'h434;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h438;

  // control register field positions
  localparam int DIR_LSB = 0;
  localparam int MODE_LSB = 8;
  localparam int PULL_LSB = 16;

  // reset values
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;
  localparam logic [NUM_PINS-1:0] DATA_RESET = 8'h00;
  localparam logic [NUM_PINS-1:0] PINS_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;

  // serial frame: one command bit, address msb first, then data msb first
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] ADDR_LAST = 6'h0B;
  localparam logic [CNT_W-1:0] DATA_LAST = 6'h1F;

  typedef enum logic [1:0] {S_CMD, S_ADDR, S_DATA, S_DONE} gpc_ser_state_t;
endpackage

/* File: gpc_serial_port.sv */
// Purpose: serial programming port front end, frame to register strobes
// Assumes: ser_clk holds each level for at least two clk cycles
// Notes: a deselect at any point abandons the frame without a write
`timescale 1ns/1ps
module gpc_serial_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ser_sel_n,
  input wire logic ser_clk,
  input wire logic ser_din,
  output logic ser_dout,
  output logic [gpc_pkg::ADDR_W-1:0] reg_addr,
  output logic [gpc_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [gpc_pkg::DATA_W-1:0] reg_rdata
);
  import gpc_pkg::*;

  gpc_ser_state_t state;
  logic sck_q;
  logic rise;
  logic is_read;
  logic [CNT_W-1:0] bit_cnt;
  logic [DATA_W-1:0] shift_in;
  logic [DATA_W-1:0] shift_out;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sck_q <= 1'b0;
    else
      sck_q <= ser_clk;
  end

  assign rise = ser_clk & ~sck_q & ~ser_sel_n;

  always_ff @(posedge clk)
  begin
    if (!rst_n || ser_sel_n)
    begin
      state <= S_CMD;
      bit_cnt <= CNT_ZERO;
      is_read <= 1'b0;
      reg_addr <= ADDR_ZERO;
      shift_in <= WORD_ZERO;
    end
    else if (rise)
    begin
      case (state)
        S_CMD:
        begin
          is_read <= ser_din;
          bit_cnt <= CNT_ZERO;
          state <= S_ADDR;
        end
        S_ADDR:
        begin
          reg_addr <= {reg_addr[ADDR_W-2:0], ser_din};
          bit_cnt <= (bit_cnt == ADDR_LAST) ? CNT_ZERO : bit_cnt + CNT_ONE;
          if (bit_cnt == ADDR_LAST)
            state <= S_DATA;
        end
        S_DATA:
        begin
          shift_in <= {shift_in[DATA_W-2:0], ser_din};
          bit_cnt <= bit_cnt + CNT_ONE;
          if (bit_cnt == DATA_LAST)
            state <= S_DONE;
        end
        S_DONE:
          state <= S_DONE;
        default:
          state <= S_CMD;
      endcase
    end
  end

  // strobes are one clk late so that reg_addr is already settled
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_wdata <= WORD_ZERO;
    end
    else
    begin
      reg_rd <= rise && state == S_ADDR && bit_cnt == ADDR_LAST && is_read;
      reg_wr <= rise && state == S_DATA && bit_cnt == DATA_LAST && !is_read;
      if (rise && state == S_DATA && bit_cnt == DATA_LAST)
        reg_wdata <= {shift_in[DATA_W-2:0], ser_din};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || ser_sel_n)
      shift_out <= WORD_ZERO;
    else if (reg_rd)
      shift_out <= reg_rdata;
    else if (rise && state == S_DATA)
      shift_out <= {shift_out[DATA_W-2:0], 1'b0};
  end

  assign ser_dout = shift_out[DATA_W-1];
endmodule

/* File: gpc_pin_control.sv */
// Purpose: eight general purpose pins with direction, weak pull and data registers
// Assumes: gpio_in is synchronous to clk; pad applies pull_en and pull_up
// Notes: configuration is reachable only over the serial programming port
`timescale 1ns/1ps
// Overview of operation
// - bits 7 to 0 of the control register set each pin's direction, 0 input and 1 output.
// - bits 15 to 8 are per-pin mode bits, 0 normal and 1 weak pull, pin 1 at bit 9, pin 0 at 8.
// - a pin's weak pull is active only when both its mode bit and its direction bit are one.
// - all configuration access goes through the serial programming port, no parallel bus.
// - bits 23 to 16 pick the pull direction of an active pull, 0 down and 1 up.
// - a separate data register lets software read the state and level of all eight pins.
module gpc_pin_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ser_sel_n,
  input wire logic ser_clk,
  input wire logic ser_din,
  output logic ser_dout,
  input wire logic [gpc_pkg::NUM_PINS-1:0] gpio_in,
  output logic [gpc_pkg::NUM_PINS-1:0] gpio_out,
  output logic [gpc_pkg::NUM_PINS-1:0] gpio_oe,
  output logic [gpc_pkg::NUM_PINS-1:0] pull_en,
  output logic [gpc_pkg::NUM_PINS-1:0] pull_up
);
  import gpc_pkg::*;

  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic [NUM_PINS-1:0] pin_direction;
  logic [NUM_PINS-1:0] pin_weak_pull_enable;
  logic [NUM_PINS-1:0] pin_pull_select;
  logic [NUM_PINS-1:0] out_value;
  logic [NUM_PINS-1:0] in_sample;
  logic [NUM_PINS-1:0] pin_level;
  logic ctrl_sel;
  logic data_sel;

  function automatic logic [DATA_W-1:0] widen(input logic [NUM_PINS-1:0] v);
    widen = {{(DATA_W-NUM_PINS){1'b0}}, v};
  endfunction

  // one decode shared by the register writes and the assertions
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  assign ctrl_sel = addr_is(reg_addr, OFS_CTRL);
  assign data_sel = addr_is(reg_addr, OFS_DATA);

  // the only register path is this serial slave
  gpc_serial_port u_serial (
    .clk(clk),
    .rst_n(rst_n),
    .ser_sel_n(ser_sel_n),
    .ser_clk(ser_clk),
    .ser_din(ser_din),
    .ser_dout(ser_dout),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  // control register, reserved bits 31:24 are not stored
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_direction <= CTRL_RESET[DIR_LSB +: NUM_PINS];
      pin_weak_pull_enable <= CTRL_RESET[MODE_LSB +: NUM_PINS];
      pin_pull_select <= CTRL_RESET[PULL_LSB +: NUM_PINS];
    end
    else if (reg_wr && ctrl_sel)
    begin
      pin_direction <= reg_wdata[DIR_LSB +: NUM_PINS];
      pin_weak_pull_enable <= reg_wdata[MODE_LSB +: NUM_PINS];
      pin_pull_select <= reg_wdata[PULL_LSB +: NUM_PINS];
    end
  end

  // data written to an input pin is kept and shows once the pin turns output
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      out_value <= DATA_RESET;
    else if (reg_wr && data_sel)
      out_value <= reg_wdata[NUM_PINS-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      in_sample <= PINS_ZERO;
    else
      in_sample <= gpio_in;
  end

  assign gpio_oe = pin_direction;
  assign gpio_out = out_value;
  // pull only on output pins, odd but that is how the pad works
  assign pull_en = pin_weak_pull_enable & pin_direction;
  assign pull_up = pin_pull_select;

  // outputs report the driven value, inputs the sampled level
  assign pin_level = (out_value & pin_direction) | (in_sample & ~pin_direction);

  always_comb
  begin
    reg_rdata = WORD_ZERO;
    case (reg_addr)
      OFS_CTRL:
        reg_rdata = widen(pin_direction) << DIR_LSB
          | widen(pin_weak_pull_enable) << MODE_LSB
          | widen(pin_pull_select) << PULL_LSB;
      OFS_DATA:
        reg_rdata = widen(pin_level);
      default:
        reg_rdata = WORD_ZERO;
    endcase
  end

  // the configuration and output checks watch the port pins, so the glue between registers and pads is covered too
  ctrl_dir_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && ctrl_sel |=> gpio_oe == $past(reg_wdata[DIR_LSB +: NUM_PINS]))
    else $error("direction did not follow control write");

  mode_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && ctrl_sel |=>
      pull_en == ($past(reg_wdata[MODE_LSB +: NUM_PINS])
        & $past(reg_wdata[DIR_LSB +: NUM_PINS])))
    else $error("pull enable wrong after control write");

  pull_needs_out_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pull_en & ~gpio_oe) == PINS_ZERO)
    else $error("pull active on an input pin");

  pull_select_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && ctrl_sel |=> pull_up == $past(reg_wdata[PULL_LSB +: NUM_PINS]))
    else $error("pull select did not follow control write");

  ctrl_reserved_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && ctrl_sel |-> (reg_rdata >> (PULL_LSB + NUM_PINS)) == WORD_ZERO)
    else $error("reserved control bits read nonzero");

  data_readback_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && data_sel |->
      reg_rdata == widen((gpio_out & gpio_oe) | ($past(gpio_in) & ~gpio_oe)))
    else $error("data register read wrong level");

  out_drive_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && data_sel |=> gpio_out == $past(reg_wdata[NUM_PINS-1:0]))
    else $error("output value did not follow data write");

  // the sample taken on the release edge is still the reset value, so start after it
  in_sample_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rst_n |=> in_sample == $past(gpio_in))
    else $error("input level not sampled");

  serial_only_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ser_sel_n |=> !reg_wr && !reg_rd)
    else $error("register strobe without serial frame");

  ctrl_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(reg_wr && ctrl_sel) |=>
      $stable(gpio_oe) && $stable(pull_en) && $stable(pull_up))
    else $error("pin configuration changed without control write");

  data_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(reg_wr && data_sel) |=> $stable(gpio_out))
    else $error("output value changed without data write");

  ctrl_view_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && ctrl_sel |-> reg_rdata[DIR_LSB +: NUM_PINS] == gpio_oe)
    else $error("direction readback differs from output enables");

  pull_view_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && ctrl_sel |->
      pull_en == (reg_rdata[MODE_LSB +: NUM_PINS] & reg_rdata[DIR_LSB +: NUM_PINS]))
    else $error("pull enables differ from mode and direction readback");

  select_view_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && ctrl_sel |-> reg_rdata[PULL_LSB +: NUM_PINS] == pull_up)
    else $error("pull select readback differs from pull direction");

  data_upper_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && data_sel |-> (reg_rdata >> NUM_PINS) == WORD_ZERO)
    else $error("upper data register bits read nonzero");

  unmapped_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && !ctrl_sel && !data_sel |-> reg_rdata == WORD_ZERO)
    else $error("unmapped address read nonzero");

  // no disable here, this one is about what reset itself does
  reset_clear_a: assert property (
    @(posedge clk)
    !rst_n |=> gpio_oe == PINS_ZERO && gpio_out == PINS_ZERO
      && pull_en == PINS_ZERO && pull_up == PINS_ZERO)
    else $error("pins not cleared by reset");

  dout_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ser_sel_n |=> !ser_dout)
    else $error("serial output active while deselected");

  wr_pulse_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");

  strobe_excl_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(reg_wr && reg_rd))
    else $error("read and write strobes together");
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the eight-pin port behind the serial programming port
// Assumes: frame is command bit, 12 address bits, 32 data bits, all msb first
// Notes: ser_clk levels last three clk cycles, above the two-cycle minimum
`timescale 1ns/1ps
module tb;
  import gpc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ser_sel_n = 1'b1;
  logic ser_clk = 1'b0;
  logic ser_din = 1'b0;
  logic [NUM_PINS-1:0] gpio_in = 8'h00;
  logic ser_dout;
  logic [NUM_PINS-1:0] gpio_out;
  logic [NUM_PINS-1:0] gpio_oe;
  logic [NUM_PINS-1:0] pull_en;
  logic [NUM_PINS-1:0] pull_up;
  logic [DATA_W-1:0] q;
  int bad_count = 0;
  int compares = 0;

  gpc_pin_control dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .ser_sel_n(ser_sel_n),
    .ser_clk(ser_clk),
    .ser_din(ser_din),
    .ser_dout(ser_dout),
    .gpio_in(gpio_in),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .pull_en(pull_en),
    .pull_up(pull_up)
  );

  always #2.5 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // n below 45 cuts the frame short by deselecting early
  task automatic xfer(input logic rd, input logic [11:0] a, input logic [31:0] d,
                      input int n, output logic [31:0] r);
    logic [44:0] f;
    f = {rd, a, d};
    r = 32'h00000000;
    @(posedge clk);
    ser_sel_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      ser_din <= f[44-i];
      ser_clk <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      if (i >= 13)
        r = {r[30:0], ser_dout};
      @(posedge clk);
      ser_clk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    ser_sel_n <= 1'b1;
    ser_clk <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b0, a, d, 45, r);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b1, a, 32'h00000000, 45, r);
    check(what, r, exp);
  endtask

  task automatic pins(input logic [7:0] oe, input logic [7:0] pe, input logic [7:0] pu);
    check("gpio_oe", {24'h000000, gpio_oe}, {24'h000000, oe});
    check("pull_en", {24'h000000, pull_en}, {24'h000000, pe});
    check("pull_up", {24'h000000, pull_up}, {24'h000000, pu});
  endtask

  initial
  begin
    // about 14 frames of 275 clk each; the limit leaves a wide margin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    pins(8'h00, 8'h00, 8'h00);
    check("gpio_out", {24'h000000, gpio_out}, 32'h00000000);
    rd_chk("ctrl reset", OFS_CTRL, 32'h00000000);
    // mode set on input pins must not pull, reserved byte reads zero
    wr(OFS_CTRL, 32'hAB55F00F);
    pins(8'h0F, 8'h00, 8'h55);
    rd_chk("ctrl", OFS_CTRL, 32'h0055F00F);
    check("ser_dout idle", {31'h00000000, ser_dout}, 32'h00000000);
    wr(OFS_CTRL, 32'h00000303);
    pins(8'h03, 8'h03, 8'h00);
    wr(OFS_CTRL, 32'h00A53C3C);
    pins(8'h3C, 8'h3C, 8'hA5);
    // outputs on 3C, inputs elsewhere; data bit 0 must not leak onto its input pin
    wr(OFS_DATA, 32'hFFFFFF35);
    check("gpio_out", {24'h000000, gpio_out}, 32'h00000035);
    @(posedge clk);
    gpio_in <= 8'h5A;
    rd_chk("data", OFS_DATA, 32'h00000076);
    @(posedge clk);
    gpio_in <= 8'hA5;
    rd_chk("data", OFS_DATA, 32'h000000B5);
    // unmapped place: write dropped, read zero
    wr(12'h430, 32'h12345678);
    rd_chk("unmapped", 12'h430, 32'h00000000);
    pins(8'h3C, 8'h3C, 8'hA5);
    // frame cut short leaves control untouched
    xfer(1'b0, OFS_CTRL, 32'h00FF00FF, 30, q);
    pins(8'h3C, 8'h3C, 8'hA5);
    rd_chk("ctrl", OFS_CTRL, 32'h00A53C3C);
    // second reset in mid-run clears the port
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    pins(8'h00, 8'h00, 8'h00);
    check("gpio_out", {24'h000000, gpio_out}, 32'h00000000);
    rd_chk("ctrl after reset", OFS_CTRL, 32'h00000000);
    rd_chk("data after reset", OFS_DATA, 32'h000000A5);
    results();
  end
endmodule
